// ===== gtc_pkg.sv
/*
 * gtc_pkg: register map, field positions, reset values and shared types for
 * the gated 16-bit timer control block.
 * assumes: one 200 MHz system clock; registers reached over classic wishbone.
 */
package gtc_pkg;

	// register byte addresses (word aligned except the flag register at 2)
	localparam logic [3:0] GTC_ADDR_CTRL = 4'h0;
	localparam logic [3:0] GTC_ADDR_GATE = 4'h4;
	localparam logic [3:0] GTC_ADDR_CNTH = 4'h8;
	localparam logic [3:0] GTC_ADDR_CNTL = 4'hc;
	localparam logic [3:0] GTC_ADDR_FLAG = 4'h2;

	// counter_control fields
	localparam int GTC_CS_LSB   = 6;
	localparam int GTC_PS_LSB   = 4;
	localparam int GTC_OSCEN    = 3;
	localparam int GTC_NSYNC    = 2;
	localparam int GTC_RUN      = 0;

	// gate_control fields
	localparam int GTC_GE       = 7;
	localparam int GTC_GPOL     = 6;
	localparam int GTC_GTM      = 5;
	localparam int GTC_GSPM     = 4;
	localparam int GTC_GGO      = 3;
	localparam int GTC_GVAL     = 2;
	localparam int GTC_GSS_LSB  = 0;

	// event flag register fields
	localparam int GTC_F_ROLL   = 0;
	localparam int GTC_F_GATE   = 1;

	localparam logic [7:0] GTC_CTRL_RST  = 8'h00;
	localparam logic [7:0] GTC_GATE_RST  = 8'h00;
	localparam logic [7:0] GTC_CTRL_WMASK = 8'hfd;
	localparam logic [7:0] GTC_GATE_WMASK = 8'hfb;
	localparam logic [1:0] GTC_DIV_STEP   = 2'h2;

	typedef enum logic [1:0]
	{
		GTC_CS_INSTR = 2'h0,
		GTC_CS_SYS   = 2'h1,
		GTC_CS_PIN   = 2'h2,
		GTC_CS_CAP   = 2'h3
	} gtc_cs_e;

	// single-pulse states, gray along idle -> armed -> in pulse
	typedef enum logic [1:0]
	{
		GTC_SP_IDLE  = 2'h0,
		GTC_SP_ARMED = 2'h1,
		GTC_SP_PULSE = 2'h3
	} gtc_sp_e;

endpackage : gtc_pkg

// ===== gtc_cnt_if.sv
/*
 * gtc_cnt_if: carries the count byte writes and the live count between the
 * register front end and the count store.
 * assumes: both ends on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface gtc_cnt_if;
	logic        inc;
	logic        wr_hi;
	logic        wr_lo;
	logic [7:0]  wdata;
	logic [15:0] count;
	logic        roll;

	modport ctrl (output inc, output wr_hi, output wr_lo, output wdata,
		input count, input roll);
	modport store (input inc, input wr_hi, input wr_lo, input wdata,
		output count, output roll);
endinterface : gtc_cnt_if
`default_nettype wire

// ===== gtc_count_store.sv
/*
 * gtc_count_store: the two count bytes with increment and byte load.
 * assumes: a byte write wins over an increment in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module gtc_count_store
	import gtc_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// count access
	gtc_cnt_if.store  cnt
);
	logic [7:0] hi_reg;
	logic [7:0] lo_reg;
	logic       roll_reg;
	wire        lo_full = (lo_reg == 8'hff);
	wire        all_full = lo_full && (hi_reg == 8'hff);

	// both bytes kept as separate holding registers
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			hi_reg   <= 8'h00;
			lo_reg   <= 8'h00;
			roll_reg <= 1'b0;
		end
		else
		begin
			roll_reg <= cnt.inc && all_full && !cnt.wr_hi && !cnt.wr_lo;
			if (cnt.wr_lo)
				lo_reg <= cnt.wdata;
			else if (cnt.inc)
				lo_reg <= lo_reg + 8'h01;
			if (cnt.wr_hi)
				hi_reg <= cnt.wdata;
			else if (cnt.inc && lo_full && !cnt.wr_lo)
				hi_reg <= hi_reg + 8'h01; // ffff wraps to 0000
		end
	end

	assign cnt.count = {hi_reg, lo_reg};
	assign cnt.roll  = roll_reg;

endmodule : gtc_count_store
`default_nettype wire

// ===== gtc_timer.sv
/*
 * gtc_timer: gated 16-bit timer control with a wishbone register slave.
 * assumes: external clock, gate pin and comparator inputs are asynchronous;
 * the overflow pulse of the 8-bit timer is on clk. a nrst with por_bor low
 * keeps the control bits (a warm reset).
 */
`timescale 1ns/1ps
`default_nettype none
module gtc_timer
	import gtc_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       por_bor,
	// wishbone slave
	input  wire logic       wb_cyc_i,
	input  wire logic       wb_stb_i,
	input  wire logic       wb_we_i,
	input  wire logic [3:0] wb_adr_i,
	input  wire logic [3:0] wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]     wb_dat_o,
	output logic            wb_ack_o,
	// clock sources
	input  wire logic       ext_clock_pin,
	input  wire logic       crystal_pins,
	input  wire logic       cap_sense_oscillator,
	// gate sources
	input  wire logic       gate_input_pin,
	input  wire logic       timer8_overflow,
	input  wire logic       comparator_a_output,
	input  wire logic       comparator_b_output,
	// status out
	output logic            dedicated_osc_on,
	output logic            rollover_flag,
	output logic            gate_event_flag
);
	logic [7:0]  ctrl_reg;
	logic [7:0]  gate_reg;
	logic        go_reg;
	logic [1:0]  fdiv_reg;
	logic [2:0]  psc_reg;
	logic [3:0]  s1_reg;
	logic [3:0]  s2_reg;
	logic [3:0]  s3_reg;
	logic        src_q_reg;
	logic        gsrc_q_reg;
	logic        tog_reg;
	logic        gval_reg;
	logic        roll_f_reg;
	logic        gate_f_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic        osc_reg;
	gtc_sp_e     sp_reg;
	gtc_sp_e     sp_next;

	gtc_cnt_if cnt ();

	gtc_count_store u_store
	(
		.clk  (clk),
		.nrst (nrst),
		.cnt  (cnt)
	);

	// outside clock picked before the synchroniser so every source gets the
	// same flops; switching source may cost one stray edge
	wire       src_pin  = ctrl_reg[GTC_CS_LSB +: 2] == GTC_CS_PIN;
	wire       pin_clk  = ctrl_reg[GTC_OSCEN] ? crystal_pins : ext_clock_pin;
	wire       ext_raw  = src_pin ? pin_clk : cap_sense_oscillator;

	// three-flop synchronisers, stage one read only by stage two
	wire [3:0] async_in = {comparator_b_output, comparator_a_output,
		gate_input_pin, ext_raw};
	always_ff @(posedge clk)
	begin
		s1_reg <= async_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	// field views
	wire [1:0] cs       = ctrl_reg[GTC_CS_LSB +: 2];
	wire [1:0] ps       = ctrl_reg[GTC_PS_LSB +: 2];
	wire       run      = ctrl_reg[GTC_RUN];
	wire       oscen    = ctrl_reg[GTC_OSCEN];
	wire       nsync    = ctrl_reg[GTC_NSYNC];
	wire       gen      = gate_reg[GTC_GE];
	wire       gpol     = gate_reg[GTC_GPOL];
	wire       gtm      = gate_reg[GTC_GTM];
	wire       gspm     = gate_reg[GTC_GSPM];
	wire [1:0] gss      = gate_reg[GTC_GSS_LSB +: 2];

	// an unsynchronised source still needs a clk sample to be seen; the bypass
	// uses stage two alone, the synchronised path adds one more stage.
	function automatic logic pick_sync(input logic bypass, input logic s2, input logic s3);
		pick_sync = bypass ? s2 : s3;
	endfunction : pick_sync

	// bypass takes stage two, the synchronised path one stage more
	wire ext_lvl  = pick_sync(nsync, s2_reg[0], s3_reg[0]);
	wire ext_rise = ext_lvl && !src_q_reg;
	wire fdiv_tick = (fdiv_reg == 2'h3);
	// internal sources ignore the sync-disable bit
	wire src_tick = (cs == GTC_CS_INSTR) ? fdiv_tick :
		(cs == GTC_CS_SYS) ? 1'b1 : ext_rise;

	// prescale: tick when low bits of the divider all ones
	// a ratio change lines up cleanly at once, since its own control write restarts the prescaler
	function automatic logic [2:0] prescale_mask(input logic [1:0] sel);
		case (sel)
			2'h3:    prescale_mask = 3'h7;
			2'h2:    prescale_mask = 3'h3;
			2'h1:    prescale_mask = 3'h1;
			2'h0:    prescale_mask = 3'h0;
			default: prescale_mask = 3'h0;
		endcase
	endfunction : prescale_mask

	wire [2:0] psc_mask = prescale_mask(ps);
	wire psc_tick = src_tick && ((psc_reg & psc_mask) == psc_mask);

	// gate path
	wire cmp_a = pick_sync(1'b0, s2_reg[2], s3_reg[2]);
	wire cmp_b = pick_sync(1'b0, s2_reg[3], s3_reg[3]);
	wire gsrc  = (gss == 2'h0) ? s2_reg[1] : (gss == 2'h1) ? timer8_overflow :
		(gss == 2'h2) ? cmp_a : cmp_b;
	wire gpoled = gsrc ~^ gpol; // active level becomes 1
	wire grise  = gpoled && !gsrc_q_reg;
	wire gtogd  = gtm ? tog_reg : gpoled;
	wire gsp    = (sp_reg == GTC_SP_PULSE) && gtogd;
	wire geff   = gspm ? gsp : gtogd;
	wire gfall  = gval_reg && !geff;
	wire do_inc = run && psc_tick && (!gen || geff);

	// single-pulse: armed waits for the gate to go active, pulse ends on fall
	always_comb
	begin
		sp_next = sp_reg;
		case (sp_reg)
			GTC_SP_IDLE:
			begin
				if (go_reg && gspm)
					sp_next = GTC_SP_ARMED;
			end
			GTC_SP_ARMED:
			begin
				// software clear of go abandons the wait
				if (!go_reg || !gspm)
					sp_next = GTC_SP_IDLE;
				else if (gtogd)
					sp_next = GTC_SP_PULSE;
			end
			GTC_SP_PULSE:
			begin
				// trailing edge of the pulse ends the acquisition
				if (!gtogd || !gspm || !go_reg)
					sp_next = GTC_SP_IDLE;
			end
			default:
			begin
				sp_next = GTC_SP_IDLE;
			end
		endcase
	end
	wire sp_done = (sp_reg == GTC_SP_PULSE) && !gtogd && gspm;

	// bus decode
	wire        req    = wb_cyc_i && wb_stb_i && !ack_reg;
	wire        wr     = req && wb_we_i && wb_sel_i[0];
	wire [7:0]  wd     = wb_dat_i[7:0];
	// a register is hit only by its exact byte address, except the flag register, hit at 2 and 3
	function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] base);
		reg_hit = (adr == base);
	endfunction : reg_hit

	wire        hit_ctl = reg_hit(wb_adr_i, GTC_ADDR_CTRL);
	wire        hit_gat = reg_hit(wb_adr_i, GTC_ADDR_GATE);
	wire        hit_cnh = reg_hit(wb_adr_i, GTC_ADDR_CNTH);
	wire        hit_cnl = reg_hit(wb_adr_i, GTC_ADDR_CNTL);
	wire        wr_ctl = wr && hit_ctl;
	wire        wr_gat = wr && hit_gat;
	wire        flg_sel = (wb_adr_i[3:2] == 2'h0) && wb_adr_i[1];
	wire [7:0]  gate_rd = {gate_reg[7:4], go_reg, gval_reg, gate_reg[1:0]};
	// unmapped addresses read zero
	wire [7:0]  rd_byte = hit_ctl ? (ctrl_reg & GTC_CTRL_WMASK) :
		hit_gat ? gate_rd :
		hit_cnh ? cnt.count[15:8] :
		hit_cnl ? cnt.count[7:0] : 8'h00;
	wire [7:0]  flag_rd = {6'h00, gate_f_reg, roll_f_reg};
	wire        wr_flg = wr && flg_sel;

	assign cnt.inc   = do_inc;
	assign cnt.wr_hi = wr && hit_cnh;
	assign cnt.wr_lo = wr && hit_cnl;
	assign cnt.wdata = wd;

	// control bits: only a power-on or brown-out reset clears them
	always_ff @(posedge clk)
	begin
		if (!nrst && por_bor)
		begin
			ctrl_reg <= GTC_CTRL_RST;
			gate_reg <= GTC_GATE_RST;
		end
		else if (nrst)
		begin
			if (wr_ctl)
				ctrl_reg <= wd & GTC_CTRL_WMASK;
			if (wr_gat)
				gate_reg <= wd & GTC_GATE_WMASK;
		end
	end

	// go bit: software sets, hardware clear wins only at done
	always_ff @(posedge clk)
	begin
		if (!nrst && por_bor)
			go_reg <= 1'b0;
		else if (nrst)
		begin
			if (sp_done)
				go_reg <= 1'b0;
			else if (wr_gat)
				go_reg <= wd[GTC_GGO];
		end
	end

	// clock dividers; a control write restarts the prescaler
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			fdiv_reg <= 2'h0;
			psc_reg  <= 3'h0;
		end
		else
		begin
			// free-running divide by four for the instruction clock
			fdiv_reg <= fdiv_reg + 2'h1;
			if (wr_ctl)
				psc_reg <= 3'h0;
			else if (src_tick)
				psc_reg <= psc_reg + 3'h1;
		end
	end

	// edge history; gate history starts high so reset gives no false rise
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			src_q_reg  <= 1'b0;
			gsrc_q_reg <= 1'b1;
			gval_reg   <= 1'b0;
		end
		else
		begin
			src_q_reg  <= ext_lvl;
			gsrc_q_reg <= gpoled;
			gval_reg   <= geff;
		end
	end

	// gate flops and oscillator enable copy
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			tog_reg <= 1'b0;
			sp_reg  <= GTC_SP_IDLE;
			osc_reg <= 1'b0;
		end
		else
		begin
			sp_reg  <= sp_next;
			osc_reg <= oscen;
			// stopping the counter must also drop the toggle state
			if (!run || !gtm)
				tog_reg <= 1'b0;
			else if (grise)
				tog_reg <= !tog_reg;
		end
	end

	// sticky event flags, write 1 to clear; a new event beats the clear
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			roll_f_reg <= 1'b0;
			gate_f_reg <= 1'b0;
		end
		else
		begin
			roll_f_reg <= cnt.roll || (roll_f_reg && !(wr_flg && wd[GTC_F_ROLL]));
			gate_f_reg <= gfall || (gate_f_reg && !(wr_flg && wd[GTC_F_GATE]));
		end
	end

	// wishbone answer one cycle after request; unmapped reads zero
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= req;
			dat_reg <= {24'h000000, flg_sel ? flag_rd : rd_byte};
		end
	end

	assign wb_ack_o         = ack_reg;
	assign wb_dat_o         = dat_reg;
	assign rollover_flag    = roll_f_reg;
	assign gate_event_flag  = gate_f_reg;
	assign dedicated_osc_on = osc_reg;

endmodule : gtc_timer
`default_nettype wire

// ===== gtc_timer_assertions.sv
/* gtc_timer_assertions: bus, status and flag checks on gtc_timer ports.
   assumes: bound into gtc_timer; one clock, nrst synchronous active low. */
`timescale 1ns/1ps
`default_nettype none
module gtc_timer_assertions
	import gtc_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// status
	input wire logic        dedicated_osc_on,
	input wire logic        rollover_flag,
	input wire logic        gate_event_flag
);
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = take && wb_we_i && wb_sel_i[0];
	wire clr = wr && wb_adr_i == 4'h2;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	ack_follows_a: assert property (take |=> wb_ack_o)
		else $error("request not acked next cycle");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(take))
		else $error("ack without request");
	upper_zero_a: assert property (wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	ctl_bit1_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 4'h0)
		|-> !wb_dat_o[1])
		else $error("unused control bit reads one");
	osc_copy_a: assert property ($past(wr && wb_adr_i == 4'h0, 2)
		|-> dedicated_osc_on == $past(wb_dat_i[GTC_OSCEN], 2))
		else $error("oscillator enable does not follow write");
	roll_hold_a: assert property (rollover_flag && !(clr && wb_dat_i[0]) |=> rollover_flag)
		else $error("rollover flag lost");
	gate_hold_a: assert property (gate_event_flag && !(clr && wb_dat_i[1])
		|=> gate_event_flag)
		else $error("gate event flag lost");
	flag_reset_a: assert property ($rose(nrst) |-> !rollover_flag && !gate_event_flag)
		else $error("flags set after reset");
	cover property (rollover_flag);
	cover property (gate_event_flag);
	cover property (clr);
endmodule : gtc_timer_assertions
bind gtc_timer gtc_timer_assertions u_chk (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.dedicated_osc_on(dedicated_osc_on), .rollover_flag(rollover_flag),
	.gate_event_flag(gate_event_flag));
`default_nettype wire

// ===== gtc_src_model.sv
/* gtc_src_model: clock and gate sources in front of the timer.
   assumes: oscillators run free at one eighth of clk; gate pin set by bench. */
`timescale 1ns/1ps
`default_nettype none
module gtc_src_model
(
	// system clock and gate level
	input  wire logic clk,
	input  wire logic gate_lvl,
	// sources
	output logic      ext_clock_pin,
	output logic      crystal_pins,
	output logic      cap_sense_oscillator,
	output logic      gate_input_pin,
	output logic      timer8_overflow,
	output logic      comparator_a_output,
	output logic      comparator_b_output
);
	logic [1:0] div_reg = 2'h0;
	initial ext_clock_pin = 1'b0;
	always @(posedge clk)
	begin
		div_reg <= div_reg + 2'h1;
		if (div_reg == 2'h3)
			ext_clock_pin <= ~ext_clock_pin;
	end
	assign crystal_pins = ext_clock_pin;
	assign cap_sense_oscillator = ext_clock_pin;
	assign gate_input_pin = gate_lvl;
	// only source b held high, so a wrong gate select shows in the count
	assign timer8_overflow = 1'b0;
	assign comparator_a_output = 1'b0;
	assign comparator_b_output = 1'b1;
endmodule : gtc_src_model
`default_nettype wire

// ===== gtc_timer_bench.sv
/* gtc_timer_bench: self-checking bench for gtc_timer over wishbone.
   assumes: gtc_src_model supplies clock and gate sources. */
`timescale 1ns/1ps
`default_nettype none
module gtc_timer_bench;
	import gtc_pkg::*;
	logic        clk, nrst, por_bor, cyc, stb, we, ack, gl;
	logic        osc, rf, gf, xc, xt, cp, gp, t8, ca, cb;
	logic [3:0]  adr, sel;
	logic [31:0] di, dq;
	logic [7:0]  c;
	logic [16:0] exp_q[$];
	int          errors, num_checks, cyc_cnt;
	gtc_timer u_dut (.clk(clk), .nrst(nrst), .por_bor(por_bor), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di),
		.wb_dat_o(dq), .wb_ack_o(ack), .ext_clock_pin(xc), .crystal_pins(xt),
		.cap_sense_oscillator(cp), .gate_input_pin(gp), .timer8_overflow(t8),
		.comparator_a_output(ca), .comparator_b_output(cb), .dedicated_osc_on(osc),
		.rollover_flag(rf), .gate_event_flag(gf));
	gtc_src_model u_src (.clk(clk), .gate_lvl(gl), .ext_clock_pin(xc), .crystal_pins(xt),
		.cap_sense_oscillator(cp), .gate_input_pin(gp), .timer8_overflow(t8),
		.comparator_a_output(ca), .comparator_b_output(cb));
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	task automatic err(input string m);
		errors++;
		$display("Error at %0t: %s", $time, m);
	endtask : err
	// e holds {tolerance, mask, value}; tolerance allows prescaler phase slack
	task automatic cmp_rd(input logic [7:0] got, input logic [16:0] e);
		logic ok;
		ok = e[16] ? (8'(got - e[7:0] + 8'h1) <= 8'h2) : ((got & e[15:8]) === e[7:0]);
		num_checks++;
		if (ok !== 1'b1)
			err($sformatf("read %h expected %h", got, e[7:0]));
	endtask : cmp_rd
	task automatic cmp_bit(input logic got, input logic e);
		num_checks++;
		if (got !== e)
			err("flag level wrong");
	endtask : cmp_bit
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		di <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m,
		input logic t);
		exp_q.push_back({t, m, e});
		wb(1'b0, a, 8'h0);
	endtask : rd
	// start and stop writes are 64 cycles apart
	task automatic run(input logic [7:0] cc, input logic [7:0] g, input logic [7:0] e,
		input logic t);
		wb(1'b1, GTC_ADDR_CNTL, 8'h0);
		wb(1'b1, GTC_ADDR_CNTH, 8'h0);
		wb(1'b1, GTC_ADDR_GATE, g);
		wb(1'b1, GTC_ADDR_CTRL, cc | 8'h01);
		repeat (61) @(posedge clk);
		wb(1'b1, GTC_ADDR_CTRL, cc & 8'hfe);
		rd(GTC_ADDR_CNTL, e, 8'hff, t);
	endtask : run
	task automatic do_reset(input logic p);
		por_bor <= p;
		nrst <= 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
	endtask : do_reset
	always @(posedge clk)
		if (ack === 1'b1 && !we && exp_q.size() > 0)
			cmp_rd(dq[7:0], exp_q.pop_front());
	always @(posedge clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			err("timeout");
			test_done();
		end
	end
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		{nrst, por_bor, cyc, stb, we, gl} = '0;
		adr = 4'h0;
		sel = 4'h1;
		di = 32'h0;
		void'($urandom(37));
		do_reset(1'b1);
		c = 8'($urandom);
		wb(1'b1, GTC_ADDR_CTRL, c);
		rd(GTC_ADDR_CTRL, c & GTC_CTRL_WMASK, 8'hff, 1'b0);
		for (int cs = 0; cs < 4; cs++)
			for (int ps = 0; ps < 4; ps++)
			begin
				c = {cs[1:0], ps[1:0], 4'h0} | (8'($urandom) & 8'h0c);
				run(c, 8'h00, 8'(64 / ((cs == 0 ? 4 : cs == 1 ? 1 : 8) << ps)),
					!(cs == 1 && ps == 0));
			end
		$display("clock test done");
		for (int s = 0; s < 4; s++)
		begin
			run(8'h40, 8'hc0 | 8'(s), (s == 3) ? 8'd64 : 8'd0, 1'b0);
			rd(GTC_ADDR_GATE, (s == 3) ? 8'h04 : 8'h00, 8'h04, 1'b0);
		end
		run(8'h40, 8'h80, 8'd64, 1'b0);
		run(8'h40, 8'h40, 8'd64, 1'b0);
		$display("gate test done");
		wb(1'b1, GTC_ADDR_CNTL, 8'hfe);
		wb(1'b1, GTC_ADDR_CNTH, 8'hff);
		wb(1'b1, GTC_ADDR_CTRL, 8'h41);
		wb(1'b1, GTC_ADDR_CTRL, 8'h40);
		cmp_bit(rf, 1'b1);
		rd(GTC_ADDR_CNTH, 8'h00, 8'hff, 1'b0);
		wb(1'b1, GTC_ADDR_FLAG, 8'h03);
		cmp_bit(rf, 1'b0);
		cmp_bit(gf, 1'b0);
		$display("rollover test done");
		wb(1'b1, GTC_ADDR_GATE, 8'hd0);
		wb(1'b1, GTC_ADDR_GATE, 8'hd8);
		rd(GTC_ADDR_GATE, 8'h08, 8'h08, 1'b0);
		gl <= 1'b1;
		repeat (8) @(posedge clk);
		gl <= 1'b0;
		repeat (8) @(posedge clk);
		cmp_bit(gf, 1'b1);
		rd(GTC_ADDR_GATE, 8'h00, 8'h08, 1'b0);
		$display("single pulse test done");
		wb(1'b1, GTC_ADDR_CTRL, 8'h41);
		wb(1'b1, GTC_ADDR_GATE, 8'h60);
		gl <= 1'b1;
		repeat (8) @(posedge clk);
		gl <= 1'b0;
		repeat (8) @(posedge clk);
		rd(GTC_ADDR_GATE, 8'h64, 8'hff, 1'b0);
		wb(1'b1, GTC_ADDR_CTRL, 8'h40);
		rd(GTC_ADDR_GATE, 8'h60, 8'hff, 1'b0);
		$display("toggle test done");
		wb(1'b1, GTC_ADDR_CTRL, 8'h38);
		cmp_bit(osc, 1'b1);
		do_reset(1'b0);
		rd(GTC_ADDR_CTRL, 8'h38, 8'hff, 1'b0);
		do_reset(1'b1);
		rd(GTC_ADDR_CTRL, 8'h00, 8'hff, 1'b0);
		rd(GTC_ADDR_GATE, 8'h00, 8'hfb, 1'b0);
		$display("reset test done");
		test_done();
	end
endmodule : gtc_timer_bench
`default_nettype wire
